// >>> design/exception_entry_sequencer.v
`timescale 1ns/100ps
`default_nettype none
`include "exc_seq_consts.vh"

module exception_entry_sequencer (
    input  wire        clk,
    input  wire        resetn,
    // Avalon-MM slave
    input  wire [4:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // Exception request from the core
    input  wire        exc_req,
    input  wire [1:0]  exc_class,
    input  wire [3:0]  exc_cause,
    input  wire [3:0]  exc_trap_num,
    input  wire [2:0]  exc_int_level,
    input  wire [7:0]  exc_cp_vector,
    input  wire [31:0] exc_pc,
    input  wire        restore_fault,
    output wire        exc_ack,
    output reg         exc_done,
    output reg         busy,
    output reg         halted,
    // Memory bus master
    output reg         mem_req,
    output reg         mem_we,
    output reg  [2:0]  mem_fc,
    output reg  [31:0] mem_addr,
    output reg  [31:0] mem_wdata,
    input  wire        mem_ack,
    input  wire        mem_berr,
    input  wire        mem_avec,
    input  wire [31:0] mem_rdata
);

    localparam [3:0] S_IDLE     = 4'h0;
    localparam [3:0] S_IACK     = 4'h1;
    localparam [3:0] S_STACK_HI = 4'h2;
    localparam [3:0] S_STACK_LO = 4'h3;
    localparam [3:0] S_FETCH_SP = 4'h4;
    localparam [3:0] S_FETCH_PC = 4'h5;
    localparam [3:0] S_PREFETCH = 4'h6;
    localparam [3:0] S_HALT     = 4'h7;
    localparam [3:0] S_ISSUE    = 4'h8;

    reg [3:0]  state_ff;
    reg [3:0]  ret_state_ff;
    reg [15:0] status_word_ff;
    reg [15:0] sw_copy_ff;
    reg [15:0] frame_sw_ff;
    reg [31:0] vector_base_register_ff;
    reg [31:0] isp_ff;
    reg [31:0] msp_ff;
    reg [31:0] program_counter_ff;
    reg [31:0] saved_pc_ff;
    reg [7:0]  vector_ff;
    reg [3:0]  frame_fmt_ff;
    reg        second_frame_ff;
    reg        is_reset_ff;
    reg        fault_ctx_ff;
    reg [1:0]  prefetch_cnt_ff;
    reg        bus_ack_ff;
    reg [1:0]  cls_ff;
    reg [2:0]  level_ff;

    wire        bus_req;
    wire [31:0] vector_addr;
    wire [31:0] active_sp;
    wire [31:0] frame_base;
    wire [11:0] vector_offset;
    wire        mem_done;
    reg  [7:0]  internal_vector;

    // Bus answers one cycle after the request is seen
    assign bus_req         = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~bus_ack_ff;
    assign exc_ack         = (state_ff == S_IDLE) & exc_req & ~restore_fault;
    assign mem_done        = mem_req & (mem_ack | mem_berr);

    // Vector address and stack addressing
    assign vector_addr   = vector_base_register_ff + {22'h0, vector_ff, 2'b00};
    assign vector_offset = {2'b00, vector_ff, 2'b00};
    assign active_sp     = status_word_ff[`SW_MASTER] ? msp_ff : isp_ff;
    assign frame_base    = active_sp - `FRAME_BYTES;

    // Internal vector generation
    always @* begin
        if (exc_cause == `CAUSE_TRAP) begin
            internal_vector = `VEC_TRAP_BASE + {4'h0, exc_trap_num};
        end else if (exc_cause == 4'h0c || exc_cause == 4'h1) begin
            internal_vector = `VEC_UNINIT;
        end else begin
            internal_vector = {4'h0, exc_cause};
        end
    end

    // Register read data and handshake
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bus_ack_ff   <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            bus_ack_ff <= bus_req & ~bus_ack_ff;
            if (avs_read & ~bus_ack_ff) begin
                case (avs_address)
                    `REG_STATUS_WORD:     avs_readdata <= {16'h0000, status_word_ff};
                    `REG_VECTOR_BASE:     avs_readdata <= vector_base_register_ff;
                    `REG_ISP:             avs_readdata <= isp_ff;
                    `REG_MSP:             avs_readdata <= msp_ff;
                    `REG_PROGRAM_COUNTER: avs_readdata <= program_counter_ff;
                    `REG_SEQ_STATE:       avs_readdata <= {20'h00000, halted, busy,
                                                           2'b00, vector_ff};
                    default:              avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Exception entry sequencer
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff                <= S_FETCH_SP;
            ret_state_ff            <= S_IDLE;
            status_word_ff          <= `SW_RESET_VAL;
            sw_copy_ff              <= 16'h0000;
            frame_sw_ff             <= 16'h0000;
            vector_base_register_ff <= 32'h0000_0000;
            isp_ff                  <= 32'h0000_0000;
            msp_ff                  <= 32'h0000_0000;
            program_counter_ff      <= 32'h0000_0000;
            saved_pc_ff             <= 32'h0000_0000;
            vector_ff               <= `VEC_RESET_SP;
            frame_fmt_ff            <= `FRAME_FMT_NORMAL;
            second_frame_ff         <= 1'b0;
            is_reset_ff             <= 1'b1;
            fault_ctx_ff            <= 1'b1;
            prefetch_cnt_ff         <= 2'h0;
            cls_ff                  <= `CLS_INTERNAL;
            level_ff                <= 3'h0;
            exc_done                <= 1'b0;
            busy                    <= 1'b1;
            halted                  <= 1'b0;
            mem_req                 <= 1'b0;
            mem_we                  <= 1'b0;
            mem_fc                  <= `FC_SUP_PROGRAM;
            mem_addr                <= 32'h0000_0000;
            mem_wdata               <= 32'h0000_0000;
        end else begin
            exc_done <= 1'b0;
            // Software writes, only while no entry is running
            if (avs_write & bus_ack_ff & (state_ff == S_IDLE)) begin
                case (avs_address)
                    `REG_STATUS_WORD:     status_word_ff <= avs_writedata[15:0];
                    `REG_VECTOR_BASE:     vector_base_register_ff <= avs_writedata;
                    `REG_ISP:             isp_ff <= avs_writedata;
                    `REG_MSP:             msp_ff <= avs_writedata;
                    `REG_PROGRAM_COUNTER: program_counter_ff <= avs_writedata;
                    default:              ;
                endcase
            end
            // Bus error inside a fault or reset entry halts the device
            if (mem_done & mem_berr & fault_ctx_ff & (state_ff != S_IACK)) begin
                state_ff <= S_HALT;
                mem_req  <= 1'b0;
                halted   <= 1'b1;
            end else if (restore_fault & (state_ff != S_HALT)) begin
                state_ff <= S_HALT;
                mem_req  <= 1'b0;
                halted   <= 1'b1;
            end else if (mem_done & mem_berr & (state_ff != S_IACK)) begin
                // Bus error during other entry, except in S_IACK: restart as bus error entry
                mem_req        <= 1'b0;
                fault_ctx_ff   <= 1'b1;
                cls_ff         <= `CLS_INTERNAL;
                vector_ff      <= `VEC_BUS_ERR;
                frame_fmt_ff   <= `FRAME_FMT_NORMAL;
                frame_sw_ff    <= sw_copy_ff;
                second_frame_ff <= 1'b0;
                state_ff       <= S_ISSUE;
                ret_state_ff   <= S_STACK_HI;
            end else begin
                case (state_ff)
                    S_IDLE: begin
                        if (exc_req) begin
                            busy           <= 1'b1;
                            sw_copy_ff     <= status_word_ff;
                            frame_sw_ff    <= status_word_ff;
                            status_word_ff[`SW_SUPERVISOR] <= 1'b1;
                            status_word_ff[`SW_TRACE_HIGH] <= 1'b0;
                            status_word_ff[`SW_TRACE_LOW]  <= 1'b0;
                            saved_pc_ff    <= exc_pc;
                            cls_ff         <= exc_class;
                            level_ff       <= exc_int_level;
                            is_reset_ff    <= 1'b0;
                            frame_fmt_ff   <= `FRAME_FMT_NORMAL;
                            fault_ctx_ff   <= (exc_class == `CLS_INTERNAL) &
                                              ((exc_cause == `CAUSE_BUS_ERR) |
                                               (exc_cause == `CAUSE_ADDR_ERR));
                            second_frame_ff <= 1'b0;
                            if (exc_class == `CLS_INTERRUPT) begin
                                status_word_ff[`SW_MASK_HI:`SW_MASK_LO] <= exc_int_level;
                                second_frame_ff <= status_word_ff[`SW_MASTER];
                                mem_req   <= 1'b1;
                                mem_we    <= 1'b0;
                                mem_fc    <= `FC_CPU_SPACE;
                                mem_addr  <= {28'hfffffff, exc_int_level, 1'b1};
                                state_ff  <= S_IACK;
                            end else begin
                                if (exc_class == `CLS_COPROC) begin
                                    vector_ff <= exc_cp_vector;
                                end else begin
                                    vector_ff <= internal_vector;
                                end
                                state_ff     <= S_ISSUE;
                                ret_state_ff <= S_STACK_HI;
                            end
                        end
                    end
                    S_IACK: begin
                        if (mem_done) begin
                            mem_req <= 1'b0;
                            if (mem_berr) begin
                                vector_ff <= `VEC_SPURIOUS;
                            end else if (mem_avec) begin
                                vector_ff <= `VEC_AUTO_BASE + {5'h00, level_ff};
                            end else begin
                                vector_ff <= mem_rdata[7:0];
                            end
                            state_ff     <= S_ISSUE;
                            ret_state_ff <= S_STACK_HI;
                        end
                    end
                    S_ISSUE: begin
                        // Start the memory access of the next step
                        mem_req <= 1'b1;
                        if (ret_state_ff == S_STACK_HI) begin
                            mem_we    <= 1'b1;
                            mem_fc    <= `FC_SUP_DATA;
                            mem_addr  <= frame_base;
                            mem_wdata <= {frame_sw_ff, saved_pc_ff[31:16]};
                        end else if (ret_state_ff == S_STACK_LO) begin
                            mem_we    <= 1'b1;
                            mem_fc    <= `FC_SUP_DATA;
                            mem_addr  <= frame_base + 32'h0000_0004;
                            mem_wdata <= {saved_pc_ff[15:0], frame_fmt_ff, vector_offset};
                        end else if (ret_state_ff == S_FETCH_PC) begin
                            mem_we    <= 1'b0;
                            mem_fc    <= is_reset_ff ? `FC_SUP_PROGRAM : `FC_SUP_DATA;
                            mem_addr  <= vector_addr;
                        end else begin
                            mem_we    <= 1'b0;
                            mem_fc    <= `FC_SUP_PROGRAM;
                            mem_addr  <= program_counter_ff +
                                         {29'h0, prefetch_cnt_ff, 1'b0};
                        end
                        state_ff <= ret_state_ff;
                    end
                    S_STACK_HI: begin
                        if (mem_done) begin
                            mem_req      <= 1'b0;
                            state_ff     <= S_ISSUE;
                            ret_state_ff <= S_STACK_LO;
                        end
                    end
                    S_STACK_LO: begin
                        if (mem_done) begin
                            mem_req <= 1'b0;
                            // Commit the frame to the active stack pointer
                            if (status_word_ff[`SW_MASTER]) begin
                                msp_ff <= frame_base;
                            end else begin
                                isp_ff <= frame_base;
                            end
                            state_ff <= S_ISSUE;
                            if (second_frame_ff) begin
                                second_frame_ff <= 1'b0;
                                status_word_ff[`SW_MASTER] <= 1'b0;
                                frame_sw_ff     <= {status_word_ff[15:13], 1'b0,
                                                    status_word_ff[11:0]};
                                frame_fmt_ff    <= `FRAME_FMT_THROWAWAY;
                                ret_state_ff    <= S_STACK_HI;
                            end else begin
                                ret_state_ff    <= S_FETCH_PC;
                            end
                        end
                    end
                    S_FETCH_SP: begin
                        // Reset entry: stack pointer from vector 0, no frame
                        if (!mem_req) begin
                            mem_req  <= 1'b1;
                            mem_we   <= 1'b0;
                            mem_fc   <= `FC_SUP_PROGRAM;
                            mem_addr <= vector_addr;
                        end else if (mem_done) begin
                            mem_req      <= 1'b0;
                            isp_ff       <= mem_rdata;
                            vector_ff    <= `VEC_RESET_PC;
                            state_ff     <= S_ISSUE;
                            ret_state_ff <= S_FETCH_PC;
                        end
                    end
                    S_FETCH_PC: begin
                        if (mem_done) begin
                            mem_req            <= 1'b0;
                            program_counter_ff <= mem_rdata;
                            prefetch_cnt_ff    <= 2'h0;
                            state_ff           <= S_ISSUE;
                            ret_state_ff       <= S_PREFETCH;
                        end
                    end
                    S_PREFETCH: begin
                        if (mem_done) begin
                            mem_req <= 1'b0;
                            if (prefetch_cnt_ff == `PREFETCH_WORDS - 2'h1) begin
                                state_ff     <= S_IDLE;
                                fault_ctx_ff <= 1'b0;
                                is_reset_ff  <= 1'b0;
                                exc_done     <= 1'b1;
                                busy         <= 1'b0;
                            end else begin
                                prefetch_cnt_ff <= prefetch_cnt_ff + 2'h1;
                                state_ff        <= S_ISSUE;
                                ret_state_ff    <= S_PREFETCH;
                            end
                        end
                    end
                    S_HALT: begin
                        // Only resetn leaves this state
                        halted  <= 1'b1;
                        mem_req <= 1'b0;
                    end
                    default: begin
                        state_ff <= S_HALT;
                    end
                endcase
            end
        end
    end

endmodule // exception_entry_sequencer
`default_nettype wire

// >>> shared/exc_seq_consts.vh
// Functional notes
// - On any exception copy status word, then set supervisor flag.
// - After entering supervisor, clear both trace control bits.
// - Reset and interrupts also update priority mask, status bits 10..8.
// - Interrupt vector comes from acknowledge read in space 1111 (0x7 code).
// - Coprocessor exceptions use the vector number from its response.
// - All other exceptions get their vector from internal logic.
// - Except reset, stack a frame on the active supervisor stack.
// - Interrupt with master flag set clears it, adds interrupt-stack frame.
// - Vector address is vector base plus vector number times four.
// - Load program counter from vector table; reset also loads stack pointer.
// - Prefetch three instruction words before resuming at new counter.
// - Bus order may vary; stack addresses and offsets follow fixed layout.
// - Vectors 0,1 come from supervisor program space; others supervisor data.
// - Internal vectors 2..11 and 13..15 for faults, traps, emulators.
// - Vector 24 spurious interrupt; 25..31 autovectors for levels 1..7.
// - Trap instructions 0..15 map to vectors 32..47.
// - Vectors 48..54 float coprocessor, 56..58 paged memory unit.
// - Vectors 64..255 are user interrupt vectors; any number accepted.
// - Reset sets mask to 7 and clears vector base before vector fetch.
// - Bus error in fault or reset entry, or on restore, halts until reset.
`ifndef EXC_SEQ_CONSTS_VH
`define EXC_SEQ_CONSTS_VH

// Register byte offsets
`define REG_STATUS_WORD     5'h00
`define REG_VECTOR_BASE     5'h04
`define REG_ISP             5'h08
`define REG_MSP             5'h0c
`define REG_PROGRAM_COUNTER 5'h10
`define REG_SEQ_STATE       5'h14

// Status word fields
`define SW_TRACE_HIGH  15
`define SW_TRACE_LOW   14
`define SW_SUPERVISOR  13
`define SW_MASTER      12
`define SW_MASK_HI     10
`define SW_MASK_LO     8
`define SW_RESET_VAL   16'h2700
`define MASK_HIGHEST   3'h7

// Function codes of bus spaces
`define FC_SUP_DATA    3'h5
`define FC_SUP_PROGRAM 3'h6
`define FC_CPU_SPACE   3'h7

// Exception classes
`define CLS_INTERNAL   2'h0
`define CLS_INTERRUPT  2'h1
`define CLS_COPROC     2'h2

// Internal cause codes (trap code uses trap number)
`define CAUSE_TRAP      4'h0
`define CAUSE_BUS_ERR   4'h2
`define CAUSE_ADDR_ERR  4'h3

// Fixed vector numbers
`define VEC_RESET_SP    8'h00
`define VEC_RESET_PC    8'h01
`define VEC_BUS_ERR     8'h02
`define VEC_ADDR_ERR    8'h03
`define VEC_SPURIOUS    8'h18
`define VEC_AUTO_BASE   8'h18
`define VEC_TRAP_BASE   8'h20
`define VEC_UNINIT      8'h0f

// Stack frame formats and layout
`define FRAME_FMT_NORMAL   4'h0
`define FRAME_FMT_THROWAWAY 4'h1
`define FRAME_BYTES        32'h0000_0008
`define PREFETCH_WORDS     2'h3

`endif

// >>> tb/mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module mem_model (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        mem_req,
    input  wire logic [2:0]  mem_fc,
    input  wire logic [31:0] mem_addr,
    input  wire logic [3:0]  lag,
    input  wire logic [1:0]  fail_mode,
    input  wire logic        use_avec,
    input  wire logic [7:0]  iack_vec,
    output logic             mem_ack,
    output logic             mem_berr,
    output logic             mem_avec,
    output logic [31:0]      mem_rdata
);
    logic [3:0] cnt_ff;
    logic       served_ff;
    logic       bad;
    // Bus error on acknowledge only, or on every access
    assign bad = (fail_mode == 2'd1 && mem_fc == 3'h7) || fail_mode == 2'd2;
    // Answers each access once after lag cycles; idle data toggles
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {cnt_ff, served_ff, mem_ack, mem_berr, mem_avec} <= '0;
            mem_rdata <= 32'h5a5a_5a5a;
        end else if (mem_req && !served_ff && cnt_ff == lag) begin
            served_ff <= 1'b1;
            cnt_ff <= 4'h0;
            mem_ack <= !bad;
            mem_berr <= bad;
            mem_avec <= use_avec && mem_fc == 3'h7;
            // Acknowledge read carries the vector number
            mem_rdata <= (mem_fc == 3'h7) ? {24'h0, iack_vec}
                                          : {16'h0, mem_addr[15:0]} + 32'h0000_1000;
        end else begin
            served_ff <= served_ff && mem_req;
            cnt_ff <= (mem_req && !served_ff) ? cnt_ff + 4'h1 : 4'h0;
            {mem_ack, mem_berr, mem_avec} <= 3'b000;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule // mem_model
`default_nettype wire

// >>> tb/exc_seq_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module exc_seq_asserts (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        exc_req,
    input wire logic        exc_ack,
    input wire logic        exc_done,
    input wire logic        busy,
    input wire logic        halted,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [2:0]  mem_fc,
    input wire logic [31:0] mem_addr,
    input wire logic        mem_ack,
    input wire logic        mem_berr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic first_ff;
    // Marks the first memory access after reset
    always @(posedge clk or negedge resetn) begin
        if (!resetn) first_ff <= 1'b1;
        else if (mem_req) first_ff <= 1'b0;
    end
    take_busy_a: assert property (exc_req && exc_ack |=> busy)
        else $error("taken exception without busy");
    idle_take_a: assert property (exc_ack |-> exc_req && !busy && !halted)
        else $error("exception taken while not idle");
    iack_space_a: assert property (mem_req && mem_fc == 3'h7 |-> !mem_we && mem_addr[0] && mem_addr[31:4] == 28'hfffffff)
        else $error("bad acknowledge cycle");
    stack_space_a: assert property (mem_req && mem_we |-> mem_fc == 3'h5)
        else $error("stack write outside supervisor data");
    req_hold_a: assert property (mem_req && !mem_ack && !mem_berr |=> mem_req && $stable(mem_addr) && $stable(mem_fc))
        else $error("memory request changed before answer");
    req_drop_a: assert property (mem_req && (mem_ack || mem_berr) |=> !mem_req)
        else $error("memory request not dropped");
    halt_stays_a: assert property (halted |=> halted && !mem_req)
        else $error("halt left without reset");
    reset_vec_a: assert property (first_ff && mem_req |-> mem_fc == 3'h6 && mem_addr == 32'h0 && !mem_we)
        else $error("first reset fetch wrong");
    done_pulse_a: assert property (exc_done |=> !exc_done)
        else $error("done longer than one cycle");
    irq_c: cover property (exc_req && exc_ack);
    iack_c: cover property (mem_req && mem_fc == 3'h7 && mem_ack);
    halt_c: cover property (halted);
endmodule // exc_seq_asserts
bind exception_entry_sequencer exc_seq_asserts chk_i (
    .clk(clk), .resetn(resetn), .exc_req(exc_req), .exc_ack(exc_ack),
    .exc_done(exc_done), .busy(busy), .halted(halted), .mem_req(mem_req),
    .mem_we(mem_we), .mem_fc(mem_fc), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_berr(mem_berr));
`default_nettype wire

// >>> tb/tb_exception_entry_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
`include "exc_seq_consts.vh"
module tb_exception_entry_sequencer;
    logic        clk = 0, resetn = 0, avs_read = 0, avs_write = 0, exc_req = 0;
    logic        restore_fault = 0, use_avec = 0;
    logic [4:0]  avs_address = 0;
    logic [31:0] avs_writedata = 0, exc_pc = 0, avs_readdata, mem_addr, mem_wdata, mem_rdata, rd;
    logic [1:0]  exc_class = 0, fail_mode = 0;
    logic [3:0]  exc_cause = 0, exc_trap_num = 0, lag = 0;
    logic [2:0]  exc_int_level = 0, mem_fc;
    logic [7:0]  exc_cp_vector = 0, iack_vec = 0;
    logic        avs_waitrequest, exc_ack, exc_done, busy, halted;
    logic        mem_req, mem_we, mem_ack, mem_berr, mem_avec;
    int          failures = 0, num_checks = 0, cycles = 0, n_acc = 0;
    logic [31:0] a_addr [16], a_data [16];
    logic [3:0]  a_kind [16];
    logic [7:0]  vi [5] = '{32, 47, 4, 11, 13};
    logic [3:0]  ci [5] = '{0, 0, 4, 11, 13};
    logic [7:0]  vq [4] = '{64, 27, 24, 66};
    logic [2:0]  lq [4] = '{5, 3, 7, 6};
    always #50 clk = ~clk;
    exception_entry_sequencer exception_entry_sequencer_i (.*);
    mem_model mem_model_i (.*);
    // Log every answered memory access
    always @(posedge clk) begin
        if (mem_req && (mem_ack || mem_berr)) begin
            a_addr[n_acc % 16] <= mem_addr;
            a_data[n_acc % 16] <= mem_wdata;
            a_kind[n_acc % 16] <= {mem_we, mem_fc};
            n_acc <= n_acc + 1;
        end
    end
    task wrap_up;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            $display("unexpected at %0t: timeout", $time);
            wrap_up();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task take(input logic [1:0] c, input logic [3:0] cs, tn, input logic [2:0] l, input logic [7:0] v);
        n_acc = 0;
        @(posedge clk);
        {exc_req, exc_class, exc_cause, exc_trap_num} <= {1'b1, c, cs, tn};
        {exc_int_level, exc_cp_vector, exc_pc} <= {l, v, 32'h1234_5678};
        @(posedge clk);
        while (exc_ack !== 1'b1) @(posedge clk);
        exc_req <= 1'b0;
        while (exc_done !== 1'b1 && halted !== 1'b1) @(negedge clk);
    endtask
    // Vector read, then three prefetches from the loaded counter
    task chk_entry(input int f, input logic [31:0] va, input logic [2:0] fc);
        logic [31:0] pc;
        pc = {16'h0, va[15:0]} + 32'h0000_1000;
        chk(a_addr[f], va);
        chk(a_kind[f], {1'b0, fc});
        for (int k = 0; k < 3; k++) begin
            chk(a_addr[f + 1 + k], pc + 2 * k);
            chk(a_kind[f + 1 + k], 4'h6);
        end
        chk(n_acc, f + 4);
    endtask
    // Frame writes in order, first stack then interrupt stack
    task scan(input logic [31:0] s0, input logic [2:0] l, input int nw);
        int w;
        w = 0;
        for (int k = 0; k < n_acc; k++) begin
            if (a_kind[k][2:0] == 3'h7) chk(a_addr[k], {28'hfffffff, l, 1'b1});
            if (a_kind[k][3]) begin
                chk(a_addr[k], (w < 2 ? s0 : 32'h800) - 8 + 4 * (w % 2));
                w++;
            end
        end
        chk(w, nw);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        while (busy !== 1'b0) @(negedge clk);
        chk(a_addr[0], 32'h0);
        chk(a_kind[0], 4'h6);
        chk_entry(1, 32'h4, 3'h6);
        bus(0, `REG_ISP, 0);
        chk(rd, 32'h1000);
        bus(0, `REG_STATUS_WORD, 0);
        chk(rd, 32'h2700);
        bus(0, `REG_VECTOR_BASE, 0);
        chk(rd, 32'h0);
        bus(1, `REG_VECTOR_BASE, 32'h200);
        bus(1, `REG_MSP, 32'h900);
        for (int i = 0; i < 5; i++) begin
            lag <= i[0] ? 4'h2 : 4'h0;
            bus(1, `REG_ISP, 32'h800);
            bus(1, `REG_STATUS_WORD, 32'hc300);
            take(0, ci[i], i[0] ? 4'hf : 4'h0, 0, 0);
            bus(0, `REG_STATUS_WORD, 0);
            chk(rd, 32'h2300);
            chk(a_data[0], 32'hc300_1234);
            chk(a_data[1], {16'h5678, 4'h0, 2'b00, vi[i], 2'b00});
            scan(32'h800, 0, 2);
            chk_entry(2, 32'h200 + vi[i] * 4, 3'h5);
        end
        for (int i = 0; i < 4; i++) begin
            {use_avec, fail_mode, iack_vec} <= {i == 1, i == 2 ? 2'd1 : 2'd0, vq[i]};
            bus(1, `REG_ISP, 32'h800);
            bus(1, `REG_STATUS_WORD, i == 3 ? 32'h3000 : 32'h2000);
            take(1, 0, 0, lq[i], 0);
            bus(0, `REG_STATUS_WORD, 0);
            chk(rd, 32'h2000 | (lq[i] << 8));
            scan(i == 3 ? 32'h900 : 32'h800, lq[i], i == 3 ? 4 : 2);
            chk_entry(i == 3 ? 5 : 3, 32'h200 + vq[i] * 4, 3'h5);
        end
        {use_avec, fail_mode} <= 3'b000;
        bus(1, `REG_ISP, 32'h800);
        take(2, 0, 0, 0, 8'h31);
        chk_entry(2, 32'h2c4, 3'h5);
        fail_mode <= 2'd2;
        take(0, 4'h2, 0, 0, 0);
        repeat (10) @(negedge clk);
        chk(halted, 1'b1);
        chk(mem_req, 1'b0);
        @(posedge clk);
        resetn <= 1'b0;
        fail_mode <= 2'd0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        while (busy !== 1'b0) @(negedge clk);
        chk(halted, 1'b0);
        @(posedge clk);
        restore_fault <= 1'b1;
        @(posedge clk);
        restore_fault <= 1'b0;
        repeat (2) @(negedge clk);
        chk(halted, 1'b1);
        wrap_up();
    end
endmodule // tb_exception_entry_sequencer
`default_nettype wire
